// ==== tb_tlb_entry_write_guestid.sv ====
`timescale 1ns/100ps
module tb_tlb_entry_write_guestid import tlbw_pkg::*;
;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = SIZE_WORD;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rd;
   logic [2:0] exc = 3'h0;
   wire [31:0] hrdata;
   wire hready, hresp, exc_c, exc_r, exc_m;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;
   int hits, slot;
   tlbw_top dut (.CLK_SYS(clk_sys), .RESET(reset), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
      .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
      .HREADYOUT(hready), .HRESP(hresp), .EXC_COP_UNUSABLE(exc_c),
      .EXC_RESERVED(exc_r), .EXC_MACHINE_CHECK(exc_m));
   always #10 clk_sys = ~clk_sys;
   // Watchdog, plus a sticky record of fault pulses
   always @(posedge clk_sys) begin
      cyc++;
      exc |= {exc_m, exc_r, exc_c};
      if (cyc == 5000) begin
         error_cnt++;
         stop_test();
      end
   end
   task stop_test();
      $display("Errors %0d, comparisons %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One single transfer; waits on the slave, never on a fixed count
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge clk_sys); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task rc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rd);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   // Runs one instruction word and compares the fault pulses it gave
   task exec(input logic [9:0] mn, input logic [2:0] e);
      wr(OFS_INSTR, {OPC_MAJOR, 10'h000, mn, OPC_FUNC});
      exc = 3'h0;
      repeat (3) @(posedge clk_sys);
      chk("faults", {29'h0, e}, {29'h0, exc});
   endtask
   task stage(input logic [31:0] pm, eh, l0, l1);
      wr(OFS_PMASK, pm);
      wr(OFS_EHI, eh);
      wr(OFS_ELO0, l0);
      wr(OFS_ELO1, l1);
   endtask
   task rb(input logic [31:0] pm, eh, l0, l1);
      rc(OFS_PMASK, pm);
      rc(OFS_EHI, eh);
      rc(OFS_ELO0, l0);
      rc(OFS_ELO1, l1);
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      // Reset value and an unmapped word
      rc(OFS_CTRL, 32'h081);
      wr(8'h80, 32'hffffffff);
      rc(8'h80, 32'h0);
      // Root write: global forced, page numbers cut under the mask
      wr(OFS_CTRL, 32'h083);
      wr(OFS_GIDS, 32'h3c11);
      stage(32'h6000, 32'h4000f812, 32'h3ff, 32'h2fe);
      wr(OFS_INDEX, 32'hb);
      exec(MIN_WI, 3'h0);
      wr(OFS_GIDS, 32'h0011);
      stage(32'h0, 32'h0, 32'h0, 32'h0);
      exec(MIN_RD, 3'h0);
      rb(32'h6000, 32'h4000e012, 32'h33f, 32'h23f);
      rc(OFS_GIDS, 32'h3c11);
      // Guest write, then read with own and with foreign guest id
      wr(OFS_CTRL, 32'h087);
      wr(OFS_GIDS, 32'h3c5a);
      stage(32'h0, 32'h80000821, 32'h1041, 32'h80);
      wr(OFS_INDEX, 32'h2);
      exec(MIN_WI, 3'h0);
      stage(32'h0, 32'h0, 32'h0, 32'h0);
      exec(MIN_RD, 3'h0);
      rb(32'h0, 32'h80000821, 32'h1040, 32'h80);
      wr(OFS_GIDS, 32'h3c5b);
      exec(MIN_RD, 3'h0);
      rb(32'h0, 32'h400, 32'h0, 32'h0);
      // Overlapping indexed write: refused, then accepted as invalidate
      wr(OFS_CTRL, 32'h283);
      wr(OFS_GIDS, 32'h3c11);
      stage(32'h6000, 32'h4000f812, 32'h3ff, 32'h3ff);
      wr(OFS_INDEX, 32'h4);
      exec(MIN_WI, 3'h4);
      wr(OFS_EHI, 32'h4000fc12);
      exec(MIN_WI, 3'h0);
      exec(MIN_RD, 3'h0);
      rb(32'h0, 32'h400, 32'h0, 32'h0);
      rc(OFS_GIDS, 32'h0011);
      // Random write into the split buffer over a live overlap
      wr(OFS_CTRL, 32'h583);
      wr(OFS_GIDS, 32'h3c11);
      stage(32'h6000, 32'h4000f812, 32'h5007, 32'h5007);
      exec(MIN_WR, 3'h0);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("overlaps", 32'h1, {24'h0, rd[15:8]});
      // Slot is unknown, so scan every root slot for the new frame
      wr(OFS_CTRL, 32'h083);
      hits = 0;
      slot = 0;
      for (int i = 0; i < 16; i++) begin
         wr(OFS_INDEX, 32'(i));
         exec(MIN_RD, 3'h0);
         bus(1'b0, OFS_ELO0, 32'h0);
         if (rd === 32'h5007) begin
            hits++;
            slot = i;
            rc(OFS_GIDS, 32'h3c11);
         end
      end
      chk("random hits", 32'h1, 32'(hits));
      chk("random half", 32'h0, 32'(slot / 8));
      // Faults: coprocessor off, no virtualization, unknown minor
      wr(OFS_CTRL, 32'h082);
      exec(MIN_WI, 3'h1);
      exec(MIN_WR, 3'h1);
      exec(MIN_RD, 3'h1);
      wr(OFS_CTRL, 32'h003);
      exec(MIN_WR, 3'h2);
      exec(10'h10d, 3'h2);
      stop_test();
   end
endmodule

// ==== tlbw_pkg.sv ====
`timescale 1ns/100ps
package tlbw_pkg;
   // Geometry
   localparam int TLB_IDX_W = 4;
   localparam int VPN_W = 19;
   localparam int PFN_W = 20;
   localparam int MASK_W = 16;
   localparam int ADDRESS_SPACE_ID_W = 8;
   localparam int GID_W = 8;
   localparam int CTRL_W = 11;
   localparam logic [15:0] FIXED_MASK_DEF = 16'h0000;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_GIDS = 8'h04;
   localparam logic [7:0] OFS_PMASK = 8'h08;
   localparam logic [7:0] OFS_EHI = 8'h0c;
   localparam logic [7:0] OFS_ELO0 = 8'h10;
   localparam logic [7:0] OFS_ELO1 = 8'h14;
   localparam logic [7:0] OFS_INDEX = 8'h18;
   localparam logic [7:0] OFS_RANDOM = 8'h1c;
   localparam logic [7:0] OFS_INSTR = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam logic [7:0] OFS_NONE = 8'hff;
   localparam logic [2:0] SIZE_WORD = 3'h2;
   // Control bits
   localparam int CB_COP_EN = 0;
   localparam int CB_GID_SUP = 1;
   localparam int CB_GUEST_MODE = 2;
   localparam int CB_DEALIAS = 3;
   localparam int CB_DEBUG = 4;
   localparam int CB_ERR_LVL = 5;
   localparam int CB_EXC_LVL = 6;
   localparam int CB_VIRT = 7;
   localparam int CB_INVSUP_LSB = 8;
   localparam int CB_SPLIT = 10;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h081;
   // Guest id register fields
   localparam int GID_CUR_LSB = 0;
   localparam int GID_ROOT_LSB = 8;
   // Staging register fields and write masks
   localparam int EH_R_LSB = 30;
   localparam int EH_VPN_LSB = 11;
   localparam int EH_INV_BIT = 10;
   localparam int EH_ADDRESS_SPACE_ID_LSB = 0;
   localparam int PM_MASK_LSB = 13;
   localparam int EL_PFN_LSB = 6;
   localparam int EL_C_LSB = 3;
   localparam int EL_D_BIT = 2;
   localparam int EL_V_BIT = 1;
   localparam int EL_G_BIT = 0;
   localparam logic [31:0] EH_WMASK = 32'hfffffcff;
   localparam logic [31:0] PM_WMASK = 32'h1fffe000;
   localparam logic [31:0] EL_WMASK = 32'h03ffffff;
   // Status bits
   localparam int ST_COPU = 0;
   localparam int ST_RSVD = 1;
   localparam int ST_MCHK = 2;
   localparam int ST_MM_LSB = 8;
   // Instruction encoding
   localparam int OPC_MAJ_LSB = 26;
   localparam int OPC_ZERO_LSB = 16;
   localparam int OPC_MIN_LSB = 6;
   localparam logic [5:0] OPC_MAJOR = 6'h00;
   localparam logic [5:0] OPC_FUNC = 6'h3c;
   localparam logic [9:0] MIN_WI = 10'h08d;
   localparam logic [9:0] MIN_WR = 10'h0cd;
   localparam logic [9:0] MIN_RD = 10'h04d;

   typedef enum logic [1:0] {OP_WI, OP_WR, OP_RD, OP_BAD} tlbw_op_t;

   typedef struct packed {
      logic hw_inval;
      logic [MASK_W-1:0] mask;
      logic [1:0] region;
      logic [VPN_W-1:0] virtual_page_pair;
      logic [ADDRESS_SPACE_ID_W-1:0] address_space_id;
      logic glob;
      logic [GID_W-1:0] guest_id;
      logic [PFN_W-1:0] pfn0;
      logic [2:0] c0;
      logic d0;
      logic v0;
      logic [PFN_W-1:0] pfn1;
      logic [2:0] c1;
      logic d1;
      logic v1;
   } tlbw_entry_t;

   // Clear page number bits that lie under the page mask
   function automatic logic [PFN_W-1:0] mask_low(input logic [PFN_W-1:0] f,
                                                 input logic [MASK_W-1:0] m);
      return f & ~PFN_W'(m);
   endfunction

   // Pack one low staging word
   function automatic logic [31:0] pack_low(input logic [PFN_W-1:0] physical_frame,
      input logic [2:0] c, input logic d, input logic v, input logic g);
      return (32'(physical_frame) << EL_PFN_LSB) | (32'(c) << EL_C_LSB) |
             (32'(d) << EL_D_BIT) | (32'(v) << EL_V_BIT) | 32'(g);
   endfunction

   // Two live entries that would hit the same address
   function automatic logic ent_match(input tlbw_entry_t a,
      input tlbw_entry_t b, input logic use_gid);
      logic [VPN_W-1:0] ign;
      ign = VPN_W'(a.mask | b.mask);
      return ~a.hw_inval & ~b.hw_inval & (a.region == b.region) &
             (((a.virtual_page_pair ^ b.virtual_page_pair) & ~ign) == '0) &
             (a.glob | b.glob | (a.address_space_id == b.address_space_id)) &
             (~use_gid | (a.guest_id == b.guest_id));
   endfunction
endpackage

// Instruction word decoder
module tlbw_decode import tlbw_pkg::*; (
   input wire logic [31:0] instr,
   output tlbw_op_t op
);
   wire [9:0] minor = instr[OPC_MIN_LSB +: 10];
   wire fixed_ok = (instr[OPC_MAJ_LSB +: 6] == OPC_MAJOR) &
                   (instr[OPC_ZERO_LSB +: 10] == 10'h000) &
                   (instr[5:0] == OPC_FUNC);
   // Anything outside the three encodings is reserved
   assign op = ~fixed_ok ? OP_BAD :
               (minor == MIN_WI) ? OP_WI :
               (minor == MIN_WR) ? OP_WR :
               (minor == MIN_RD) ? OP_RD : OP_BAD;
endmodule

// ==== tlbw_top.sv ====
`timescale 1ns/100ps
module tlbw_top import tlbw_pkg::*; #(
   parameter int IDX_W = TLB_IDX_W,
   parameter logic [MASK_W-1:0] FIXED_MASK = FIXED_MASK_DEF
) (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output logic EXC_COP_UNUSABLE,
   output logic EXC_RESERVED,
   output logic EXC_MACHINE_CHECK
);
   localparam int ENTRIES = 2 ** IDX_W;

   tlbw_entry_t root_tlb [ENTRIES];
   tlbw_entry_t guest_tlb [ENTRIES];
   logic [CTRL_W-1:0] ctrl;
   logic [GID_W-1:0] cur_gid;
   logic [GID_W-1:0] root_guest_id;
   logic [31:0] pmask;
   logic [31:0] ehi;
   logic [31:0] elo0;
   logic [31:0] elo1;
   logic [IDX_W-1:0] index;
   logic [IDX_W-1:0] rnd;
   logic [31:0] instr;
   logic [2:0] sticky;
   logic [7:0] mm_cnt;
   logic busy;
   logic wr_pend;
   logic rd_pend;
   logic [7:0] wr_addr;
   logic [7:0] rd_addr;
   tlbw_op_t op;

   // Bus address phase
   wire acc = HSEL & HTRANS[1] & HREADY;
   wire addr_ok = (HADDR[31:8] == 24'h0) & (HADDR[1:0] == 2'h0);
   wire wr_do = wr_pend & HREADYOUT;
   wire rd_do = rd_pend & ~busy;
   wire wr_ctrl = wr_do & (wr_addr == OFS_CTRL);
   wire wr_gids = wr_do & (wr_addr == OFS_GIDS);
   wire wr_pm = wr_do & (wr_addr == OFS_PMASK);
   wire wr_ehi = wr_do & (wr_addr == OFS_EHI);
   wire wr_elo0 = wr_do & (wr_addr == OFS_ELO0);
   wire wr_elo1 = wr_do & (wr_addr == OFS_ELO1);
   wire wr_idx = wr_do & (wr_addr == OFS_INDEX);
   wire wr_stat = wr_do & (wr_addr == OFS_STATUS);
   wire instr_go = wr_do & (wr_addr == OFS_INSTR);
   // Reads wait one cycle so they see a finished operation
   wire next_hready = ~((acc & ~HWRITE) | instr_go | (rd_pend & ~rd_do));

   tlbw_decode u_decode (
      .instr(instr),
      .op(op)
   );

   // Mode and configuration decode
   wire cop_ok = ctrl[CB_COP_EN];
   wire gid_sup = ctrl[CB_GID_SUP];
   wire virt = ctrl[CB_VIRT];
   wire [1:0] inv_sup = ctrl[CB_INVSUP_LSB +: 2];
   wire guest_ctx = ctrl[CB_GUEST_MODE] & ~ctrl[CB_DEBUG] &
                    ~ctrl[CB_ERR_LVL] & ~ctrl[CB_EXC_LVL];
   wire root_mode = ~guest_ctx;
   wire is_buf_op = (op == OP_WI) | (op == OP_WR) | (op == OP_RD);
   wire fault_cop = busy & ~cop_ok & is_buf_op;
   wire fault_ri = busy & ((op == OP_BAD) |
                   (cop_ok & (op == OP_WR) & ~virt));
   wire do_wi = busy & cop_ok & (op == OP_WI);
   wire do_wr = busy & cop_ok & virt & (op == OP_WR);
   wire do_rd = busy & cop_ok & (op == OP_RD);

   // Staging register fields
   wire [MASK_W-1:0] pm_mask = pmask[PM_MASK_LSB +: MASK_W];
   wire entry_invalidate_flag = ehi[EH_INV_BIT];
   wire [PFN_W-1:0] vpn_clr = mask_low({1'b0, ehi[EH_VPN_LSB +: VPN_W]},
                                       pm_mask);
   wire [PFN_W-1:0] pfn0_clr = mask_low(elo0[EL_PFN_LSB +: PFN_W], pm_mask);
   wire [PFN_W-1:0] pfn1_clr = mask_low(elo1[EL_PFN_LSB +: PFN_W], pm_mask);

   // Slot choice; the lower half of a split buffer holds variable pages
   wire fixed_size = (pm_mask == FIXED_MASK);
   wire [IDX_W-1:0] rnd_slot = ctrl[CB_SPLIT] ?
                    {fixed_size, rnd[IDX_W-2:0]} : rnd;
   wire [IDX_W-1:0] slot = do_wr ? rnd_slot : index;
   wire tlbw_entry_t old_ent = root_mode ? root_tlb[slot] : guest_tlb[slot];

   // New entry contents
   wire force_glob = gid_sup & ~ctrl[CB_DEALIAS] & root_mode &
                     (root_guest_id != '0);
   wire glob_new = force_glob | (elo0[EL_G_BIT] & elo1[EL_G_BIT]);
   wire inval_upd = (do_wi & (inv_sup >= 2'h2)) |
                    (do_wr & (inv_sup == 2'h1));
   wire [GID_W-1:0] gid_new = do_wi ? (root_mode ? root_guest_id : cur_gid) :
                    (gid_sup ? root_guest_id : old_ent.guest_id);
   wire tlbw_entry_t new_ent = '{
      hw_inval: inval_upd ? entry_invalidate_flag : old_ent.hw_inval,
      mask: pm_mask,
      region: ehi[EH_R_LSB +: 2],
      virtual_page_pair: vpn_clr[VPN_W-1:0],
      address_space_id: ehi[EH_ADDRESS_SPACE_ID_LSB +: ADDRESS_SPACE_ID_W],
      glob: glob_new,
      guest_id: gid_new,
      pfn0: pfn0_clr,
      c0: elo0[EL_C_LSB +: 3],
      d0: elo0[EL_D_BIT],
      v0: elo0[EL_V_BIT],
      pfn1: pfn1_clr,
      c1: elo1[EL_C_LSB +: 3],
      d1: elo1[EL_D_BIT],
      v1: elo1[EL_V_BIT]
   };

   // Overlap search against every other slot of the target buffer
   logic [ENTRIES-1:0] match_vec;
   logic [ENTRIES-1:0] upd_en;
   tlbw_entry_t upd_ent [ENTRIES];
   wire commit_hit_any = do_wi | do_wr;
   wire mchk = do_wi & (|match_vec) & ~entry_invalidate_flag;
   wire commit = (do_wi & ~mchk) | do_wr;
   genvar k;
   for (k = 0; k < ENTRIES; k++) begin : g_slot
      wire tlbw_entry_t cur = root_mode ? root_tlb[k] : guest_tlb[k];
      wire own = (slot == IDX_W'(k));
      wire kill = do_wr & match_vec[k];
      tlbw_entry_t killed;
      assign match_vec[k] = commit_hit_any & ~own &
                            ent_match(cur, new_ent, gid_sup);
      assign upd_en[k] = (commit & own) | kill;
      always_comb begin
         killed = cur;
         killed.hw_inval = 1'b1;
      end
      assign upd_ent[k] = (commit & own) ? new_ent : killed;
   end
   wire [7:0] mm_new = 8'($countones(match_vec));

   // Indexed read path
   wire tlbw_entry_t rd_ent = root_mode ? root_tlb[index] : guest_tlb[index];
   wire rd_dead = (inv_sup >= 2'h2) & rd_ent.hw_inval;
   wire rd_foreign = gid_sup & guest_ctx &
                     (rd_ent.guest_id != cur_gid);
   wire rd_zero = rd_dead | rd_foreign;
   wire [PFN_W-1:0] rd_vpn = mask_low({1'b0, rd_ent.virtual_page_pair}, rd_ent.mask);
   wire [31:0] rd_ehi = rd_zero ? (32'h1 << EH_INV_BIT) :
                        ((32'(rd_ent.region) << EH_R_LSB) |
                         (32'(rd_vpn[VPN_W-1:0]) << EH_VPN_LSB) |
                         32'(rd_ent.address_space_id));
   wire [31:0] rd_pm = rd_zero ? 32'h0 : (32'(rd_ent.mask) << PM_MASK_LSB);
   wire [31:0] rd_lo0 = rd_zero ? 32'h0 :
                        pack_low(mask_low(rd_ent.pfn0, rd_ent.mask),
                                 rd_ent.c0, rd_ent.d0, rd_ent.v0, rd_ent.glob);
   wire [31:0] rd_lo1 = rd_zero ? 32'h0 :
                        pack_low(mask_low(rd_ent.pfn1, rd_ent.mask),
                                 rd_ent.c1, rd_ent.d1, rd_ent.v1, rd_ent.glob);
   wire rid_load = do_rd & gid_sup & root_mode;
   wire [GID_W-1:0] rid_new = rd_dead ? '0 : rd_ent.guest_id;

   // Register read selection
   wire [2:0] st_set = {mchk, fault_ri, fault_cop};
   wire [31:0] rd_mux =
      (rd_addr == OFS_CTRL) ? 32'(ctrl) :
      (rd_addr == OFS_GIDS) ? 32'({root_guest_id, cur_gid}) :
      (rd_addr == OFS_PMASK) ? pmask :
      (rd_addr == OFS_EHI) ? ehi :
      (rd_addr == OFS_ELO0) ? elo0 :
      (rd_addr == OFS_ELO1) ? elo1 :
      (rd_addr == OFS_INDEX) ? 32'(index) :
      (rd_addr == OFS_RANDOM) ? 32'(rnd) :
      (rd_addr == OFS_INSTR) ? instr :
      (rd_addr == OFS_STATUS) ? ((32'(mm_cnt) << ST_MM_LSB) | 32'(sticky)) :
      32'h0;

   // Bus handshake state
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         wr_addr <= OFS_NONE;
         rd_addr <= OFS_NONE;
      end else begin
         HREADYOUT <= next_hready;
         HRESP <= 1'b0; // Every transfer answers OKAY
         // A stalled data phase keeps its pending write until ready
         wr_pend <= (acc & HWRITE & addr_ok & (HSIZE == SIZE_WORD)) |
                    (wr_pend & ~HREADY);
         if (acc) begin
            wr_addr <= HADDR[7:0];
            rd_addr <= addr_ok ? HADDR[7:0] : OFS_NONE;
         end
         rd_pend <= (acc & ~HWRITE) | (rd_pend & ~rd_do);
      end
   end

   // Read data is a flop, loaded once the operation has settled
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         HRDATA <= 32'h0;
      end else if (rd_do) begin
         HRDATA <= rd_mux;
      end
   end

   // Configuration, index and sequencing
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         ctrl <= CTRL_RESET;
         cur_gid <= '0;
         index <= '0;
         instr <= 32'h0;
         busy <= 1'b0;
         rnd <= '1;
      end else begin
         if (wr_ctrl) ctrl <= HWDATA[CTRL_W-1:0];
         if (wr_gids) cur_gid <= HWDATA[GID_CUR_LSB +: GID_W];
         if (wr_idx) index <= HWDATA[IDX_W-1:0];
         if (instr_go) instr <= HWDATA;
         busy <= instr_go;
         rnd <= rnd - 1'b1; // Free-running victim pointer
      end
   end

   // Staging registers, written by software or by an indexed read
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         pmask <= 32'h0;
         ehi <= 32'h0;
         elo0 <= 32'h0;
         elo1 <= 32'h0;
      end else if (do_rd) begin
         pmask <= rd_pm;
         ehi <= rd_ehi;
         elo0 <= rd_lo0;
         elo1 <= rd_lo1;
      end else begin
         if (wr_pm) pmask <= HWDATA & PM_WMASK;
         if (wr_ehi) ehi <= HWDATA & EH_WMASK;
         if (wr_elo0) elo0 <= HWDATA & EL_WMASK;
         if (wr_elo1) elo1 <= HWDATA & EL_WMASK;
      end
   end

   // Root guest id: software write or read-back capture
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         root_guest_id <= '0;
      end else if (rid_load) begin
         root_guest_id <= rid_new;
      end else if (wr_gids) begin
         root_guest_id <= HWDATA[GID_ROOT_LSB +: GID_W];
      end
   end

   // Sticky fault flags; a new fault beats a clear in the same cycle
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         sticky <= 3'h0;
         mm_cnt <= 8'h0;
         EXC_COP_UNUSABLE <= 1'b0;
         EXC_RESERVED <= 1'b0;
         EXC_MACHINE_CHECK <= 1'b0;
      end else begin
         sticky <= (sticky & ~(wr_stat ? HWDATA[2:0] : 3'h0)) | st_set;
         if (do_wr) mm_cnt <= mm_new;
         EXC_COP_UNUSABLE <= st_set[ST_COPU];
         EXC_RESERVED <= st_set[ST_RSVD];
         EXC_MACHINE_CHECK <= st_set[ST_MCHK];
      end
   end

   // Buffer arrays; only the buffer of the current mode is touched
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         for (int i = 0; i < ENTRIES; i++) begin
            root_tlb[i] <= '0;
            guest_tlb[i] <= '0;
         end
      end else begin
         for (int i = 0; i < ENTRIES; i++) begin
            if (upd_en[i] & root_mode) root_tlb[i] <= upd_ent[i];
            if (upd_en[i] & ~root_mode) guest_tlb[i] <= upd_ent[i];
         end
      end
   end
endmodule

// ==== tlbw_top_asserts.sv ====
`timescale 1ns/100ps
module tlbw_asserts import tlbw_pkg::*; (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   input wire logic HREADYOUT,
   input wire logic EXC_COP_UNUSABLE,
   input wire logic EXC_RESERVED,
   input wire logic EXC_MACHINE_CHECK
);
   logic ap_v, iw, entry_invalidate_flag, eh_ok;
   logic [7:0] ap_a;
   logic [31:0] ctrl, ins;
   // Bus tracking; only whole aligned words in the low page are stored
   wire take = HSEL & HTRANS[1] & HREADY;
   wire ok_wr = HWRITE & (HSIZE == SIZE_WORD) & (HADDR[31:8] == 24'h0)
      & (HADDR[1:0] == 2'h0);
   wire dwr = ap_v & HREADYOUT;
   // Instruction decode of the last executed word
   wire fmt = (ins[31:26] == OPC_MAJOR) & (ins[25:16] == 10'h000)
      & (ins[5:0] == OPC_FUNC);
   wire is_wi = fmt & (ins[15:6] == MIN_WI);
   wire is_wr = fmt & (ins[15:6] == MIN_WR);
   wire is_rd = fmt & (ins[15:6] == MIN_RD);
   wire cop = ctrl[CB_COP_EN];
   wire virt = ctrl[CB_VIRT];
   wire any_exc = EXC_COP_UNUSABLE | EXC_RESERVED | EXC_MACHINE_CHECK;
   // Shadow state; a read may rewrite the flag, so it is trusted
   // only until the next read instruction
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         ap_v <= 1'b0;
         ap_a <= 8'h00;
         iw <= 1'b0;
         ctrl <= 32'(CTRL_RESET);
         ins <= 32'h0;
         entry_invalidate_flag <= 1'b0;
         eh_ok <= 1'b1;
      end else begin
         iw <= dwr & (ap_a == OFS_INSTR);
         if (take | dwr) ap_v <= take & ok_wr;
         if (take) ap_a <= HADDR[7:0];
         if (dwr & (ap_a == OFS_CTRL)) ctrl <= HWDATA;
         if (dwr & (ap_a == OFS_INSTR)) ins <= HWDATA;
         if (dwr & (ap_a == OFS_EHI)) entry_invalidate_flag <= HWDATA[EH_INV_BIT];
         eh_ok <= (dwr & (ap_a == OFS_EHI)) | (eh_ok & ~(iw & is_rd));
      end
   end
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RESET);
   property p_cop; iw & ~cop |=> EXC_COP_UNUSABLE; endproperty
   a_cop: assert property (p_cop) else $error("no cop fault");
   property p_cop_q; iw & ~cop |=> ~EXC_RESERVED [*2]; endproperty
   a_cop_q: assert property (p_cop_q) else $error("stray fault");
   property p_bad; iw & cop & ~(is_wi | is_wr | is_rd) |=> EXC_RESERVED;
   endproperty
   a_bad: assert property (p_bad) else $error("no reserved fault");
   property p_ok; iw & cop & (is_wi | is_rd | (is_wr & virt))
      |=> ~EXC_RESERVED; endproperty
   a_ok: assert property (p_ok) else $error("bad decode");
   property p_nvz; iw & cop & is_wr & ~virt |=> EXC_RESERVED; endproperty
   a_nvz: assert property (p_nvz) else $error("no virt fault");
   property p_inv; iw & is_wi & eh_ok & entry_invalidate_flag |=> ~EXC_MACHINE_CHECK;
   endproperty
   a_inv: assert property (p_inv) else $error("check on invalidate");
   property p_wr; iw & is_wr |=> ~EXC_MACHINE_CHECK ##1 ~EXC_MACHINE_CHECK;
   endproperty
   a_wr: assert property (p_wr) else $error("check on random");
   property p_cause; any_exc |-> $past(iw); endproperty
   a_cause: assert property (p_cause) else $error("fault w/o op");
endmodule

bind tlbw_top tlbw_asserts u_chk (.CLK_SYS(CLK_SYS), .RESET(RESET),
   .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
   .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
   .HREADYOUT(HREADYOUT), .EXC_COP_UNUSABLE(EXC_COP_UNUSABLE),
   .EXC_RESERVED(EXC_RESERVED), .EXC_MACHINE_CHECK(EXC_MACHINE_CHECK));
